// ===== adcis_analog_side.sv
`timescale 1ns/1ps
`default_nettype none
module adcis_analog_side (
   input wire logic rc_run,
   input wire logic [15:0] level_set,
   output logic [15:0] pin_level,
   output logic rc_clock_tick
);
   // RC source unrelated to pclk; held low while rc_run is low
   initial rc_clock_tick = 1'b0;
   always #47 rc_clock_tick = rc_run ? ~rc_clock_tick : 1'b0;
   assign pin_level = level_set;
endmodule
`default_nettype wire

// ===== adcis_pkg.sv
package adcis_pkg;
   // APB byte addresses: configuration, port read and status registers, and an unmapped event address
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
   localparam logic [7:0] ADDR_CTRL_THREE = 8'h08;
   localparam logic [7:0] ADDR_INPUT_SEL = 8'h0C;
   localparam logic [7:0] ADDR_PIN_CFG = 8'h10;
   localparam logic [7:0] ADDR_SCAN_SEL = 8'h14;
   localparam logic [7:0] ADDR_PORT_READ = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_EVENT = 8'h20;
   // Field positions
   localparam int MODULE_ON_BIT = 15;
   localparam int SIM_SAMPLE_BIT = 3;
   localparam int REFSEL_LSB = 13;
   localparam int CHCNT_LSB = 8;
   localparam int SCAN_EN_BIT = 10;
   localparam int ALT_EN_BIT = 0;
   localparam int RC_SEL_BIT = 7;
   localparam int DIV_LSB = 0;
   localparam int UPOS_BIT = 5;
   localparam int UNEG_LSB = 6;
   localparam int CH0NEG_BIT = 4;
   localparam int ALT_FIELD_LSB = 8;
   localparam int EV_SAMPLE_BIT = 0;
   localparam int EV_IRQ_BIT = 1;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // Conversion timing
   localparam int TAD_PER_CONV = 12;
   localparam real TAD_MIN_NS = 83.33;
   localparam real PCLK_NS = 25.0;
   localparam int TAD_MIN_CYC = int'($ceil(TAD_MIN_NS / PCLK_NS));
   // Negative input codes
   localparam logic [4:0] NEG_VREF_MINUS = 5'h10;
   localparam logic [4:0] SEL_GROUND = 5'h1F;
   typedef enum logic [2:0] {
      ADCIS_REF_INTERNAL,
      ADCIS_REF_EXT_HIGH,
      ADCIS_REF_EXT_LOW,
      ADCIS_REF_EXT_BOTH
   } adcis_ref_e;
endpackage

// ===== adcis_top.sv
// Notes on behaviour
// - Reference field picks rails or reference pins
// - A conversion lasts twelve conversion clocks
// - Six-bit divider: period is cycle times (n+2)/2, rounded down
// - RC select overrides the divider field
// - Clear config bit means analog; resets clear
// - Analog pin: buffer off, port reads zero
// - Digital pin: mux input tied to ground
// - Four-bit field picks channel zero positive
// - One bit picks channel zero negative input
// - Alternate bit toggles primary and alternate sets
// - Toggle per sample time or after the last channel
// - Scan enable steps through marked inputs
// - Scan lowest to highest, restart at interrupt
// - Scan drives only channel zero positive
// - Scan replaces only the primary set
// - Group bit maps inputs 0-2 or 3-5
// - Negative group: reference, input 6 or input 9
// - Upper channels alternate their group sets
// - Module off powers down both portions
// - Channel count gives one, two or four
// - Simultaneous bit ignored for single channel
`timescale 1ns/1ps
`default_nettype none
module adcis_top #(
   parameter int N_INPUTS = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] pin_level,
   input wire logic rc_clock_tick,
   input wire logic sample_event,
   input wire logic [1:0] sample_channel,
   input wire logic conv_irq_event,
   output logic module_powered,
   output logic [2:0] reference_select,
   output logic [15:0] digital_buffer_en,
   output logic conv_clock_tick,
   output logic conversion_done,
   output logic [4:0] ch0_pos_sel,
   output logic [4:0] ch0_neg_sel,
   output logic [4:0] ch1_pos_sel,
   output logic [4:0] ch2_pos_sel,
   output logic [4:0] ch3_pos_sel,
   output logic [4:0] chx_neg_sel,
   output logic [1:0] channel_count_select,
   output logic simultaneous_sample
);
   logic [15:0] ctrl_one_q;
   logic [15:0] ctrl_two_q;
   logic [15:0] ctrl_three_q;
   logic [15:0] input_sel_q;
   logic [15:0] pin_cfg_q;
   logic [15:0] scan_sel_q;
   logic [15:0] pin_meta_q;
   logic [15:0] pin_sync_q;
   logic [1:0] rc_meta_q;
   logic rc_prev_q;
   logic use_alt_q;
   logic [3:0] scan_ptr_q;
   logic [6:0] div_cnt_q;
   logic half_tick_q;
   logic [3:0] tad_cnt_q;
   logic [1:0] ev_q;
   logic acc;
   logic on;
   logic alt_en;
   logic scan_en;
   logic tad_tick;
   logic [3:0] ch0_pos_src;
   logic [4:0] upper_pos_base;
   logic [15:0] port_read;

   // Ground selected when the addressed pin is digital
   function automatic logic [4:0] route_pin(input logic [4:0] idx, input logic [15:0] cfg);
      logic [4:0] r;
      r = idx;
      if (idx < 5'(N_INPUTS) && cfg[idx[3:0]])
         r = adcis_pkg::SEL_GROUND;
      return r;
   endfunction

   // Next marked input above the pointer, wrapping to the lowest
   function automatic logic [3:0] next_marked(input logic [3:0] from, input logic [15:0] mask,
      input logic wrap);
      logic [3:0] r;
      logic found;
      r = 4'h0;
      found = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         if (mask[i] && (wrap || i > int'(from)))
         begin
            r = 4'(i);
            found = 1'b1;
         end
      end
      if (!found)
         r = next_low(mask);
      return r;
   endfunction

   function automatic logic [3:0] next_low(input logic [15:0] mask);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--)
      begin
         if (mask[i])
            r = 4'(i);
      end
      return r;
   endfunction

   assign acc = psel && penable;
   assign on = ctrl_one_q[adcis_pkg::MODULE_ON_BIT];
   assign alt_en = ctrl_two_q[adcis_pkg::ALT_EN_BIT];
   assign scan_en = ctrl_two_q[adcis_pkg::SCAN_EN_BIT];

   // Register writes; software honours the quiet-while-on fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_one_q <= adcis_pkg::REG_RESET;
         ctrl_two_q <= adcis_pkg::REG_RESET;
         ctrl_three_q <= adcis_pkg::REG_RESET;
         input_sel_q <= adcis_pkg::REG_RESET;
         pin_cfg_q <= adcis_pkg::REG_RESET;
         scan_sel_q <= adcis_pkg::REG_RESET;
      end
      else if (clk_en && acc && pwrite)
      begin
         unique case (paddr)
            adcis_pkg::ADDR_CTRL_ONE: ctrl_one_q <= pwdata[15:0];
            adcis_pkg::ADDR_CTRL_TWO: ctrl_two_q <= pwdata[15:0];
            adcis_pkg::ADDR_CTRL_THREE: ctrl_three_q <= pwdata[15:0];
            adcis_pkg::ADDR_INPUT_SEL: input_sel_q <= pwdata[15:0];
            adcis_pkg::ADDR_PIN_CFG: pin_cfg_q <= pwdata[15:0];
            adcis_pkg::ADDR_SCAN_SEL: scan_sel_q <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Analog pins read as zero on the port
   assign port_read = pin_sync_q & pin_cfg_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel && !penable && !pwrite)
         begin
            unique case (paddr)
               adcis_pkg::ADDR_CTRL_ONE: prdata <= {16'h0000, ctrl_one_q};
               adcis_pkg::ADDR_CTRL_TWO: prdata <= {16'h0000, ctrl_two_q};
               adcis_pkg::ADDR_CTRL_THREE: prdata <= {16'h0000, ctrl_three_q};
               adcis_pkg::ADDR_INPUT_SEL: prdata <= {16'h0000, input_sel_q};
               adcis_pkg::ADDR_PIN_CFG: prdata <= {16'h0000, pin_cfg_q};
               adcis_pkg::ADDR_SCAN_SEL: prdata <= {16'h0000, scan_sel_q};
               adcis_pkg::ADDR_PORT_READ: prdata <= {16'h0000, port_read};
               adcis_pkg::ADDR_STATUS: prdata <= {23'h000000, use_alt_q, scan_ptr_q, tad_cnt_q};
               default: prdata <= 32'h00000000;
            endcase
         end
         if (psel && !penable)
         begin
            unique case (paddr)
               adcis_pkg::ADDR_CTRL_ONE, adcis_pkg::ADDR_CTRL_TWO, adcis_pkg::ADDR_CTRL_THREE,
               adcis_pkg::ADDR_INPUT_SEL, adcis_pkg::ADDR_PIN_CFG, adcis_pkg::ADDR_SCAN_SEL,
               adcis_pkg::ADDR_PORT_READ, adcis_pkg::ADDR_STATUS: pslverr <= 1'b0;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Pin and RC tick synchronisers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta_q <= 16'h0000;
         pin_sync_q <= 16'h0000;
         rc_meta_q <= 2'h0;
         rc_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         pin_meta_q <= pin_level;
         pin_sync_q <= pin_meta_q;
         rc_meta_q <= {rc_meta_q[0], rc_clock_tick};
         rc_prev_q <= rc_meta_q[1];
      end
   end

   // Half-cycle ticks: two per pclk; counter reloads at divider+2, rounded down to even
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_cnt_q <= 7'h00;
         half_tick_q <= 1'b0;
      end
      else if (clk_en)
      begin
         half_tick_q <= 1'b0;
         if (!on)
            div_cnt_q <= 7'h00;
         else if (div_cnt_q + 7'h02 > {1'b0, ctrl_three_q[5:0]})
         begin
            // Period (n+2)/2 pclk; odd n rounds down to whole pclk
            div_cnt_q <= 7'h00;
            half_tick_q <= 1'b1;
         end
         else
            div_cnt_q <= div_cnt_q + 7'h02;
      end
   end

   // RC select ignores the divider
   assign tad_tick = ctrl_three_q[adcis_pkg::RC_SEL_BIT] ? (rc_meta_q[1] && !rc_prev_q) : half_tick_q;

   // Twelve conversion clocks per conversion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tad_cnt_q <= 4'h0;
         conv_clock_tick <= 1'b0;
         conversion_done <= 1'b0;
      end
      else if (clk_en)
      begin
         conv_clock_tick <= on && tad_tick;
         conversion_done <= 1'b0;
         if (!on)
            tad_cnt_q <= 4'h0;
         else if (tad_tick)
         begin
            if (tad_cnt_q == 4'(adcis_pkg::TAD_PER_CONV - 1))
            begin
               tad_cnt_q <= 4'h0;
               conversion_done <= 1'b1;
            end
            else
               tad_cnt_q <= tad_cnt_q + 4'h1;
         end
      end
   end

   // Alternation and scan pointer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         use_alt_q <= 1'b0;
         scan_ptr_q <= 4'h0;
      end
      else if (clk_en)
      begin
         if (!on || !alt_en)
            use_alt_q <= 1'b0;
         else if (sample_event)
         begin
            // Sequential: toggle after the last channel so a sequence shares one set
            if (simultaneous_sample || sample_channel == (channel_count_select == 2'h2 ? 2'h3 : channel_count_select))
               use_alt_q <= !use_alt_q;
         end
         if (conv_irq_event || !scan_en)
            scan_ptr_q <= next_low(scan_sel_q);
         else if (sample_event && sample_channel == 2'h0 && !use_alt_q)
            scan_ptr_q <= next_marked(scan_ptr_q, scan_sel_q, 1'b0);
      end
   end

   // Scan replaces the primary positive only
   assign ch0_pos_src = use_alt_q ? input_sel_q[11:8] : (scan_en ? scan_ptr_q : input_sel_q[3:0]);
   assign upper_pos_base = (use_alt_q ? input_sel_q[13] : input_sel_q[5]) ? 5'h03 : 5'h00;

   // Multiplexer selections, all registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ch0_pos_sel <= 5'h00;
         ch0_neg_sel <= adcis_pkg::NEG_VREF_MINUS;
         ch1_pos_sel <= 5'h00;
         ch2_pos_sel <= 5'h00;
         ch3_pos_sel <= 5'h00;
         chx_neg_sel <= adcis_pkg::NEG_VREF_MINUS;
      end
      else if (clk_en)
      begin
         ch0_pos_sel <= route_pin({1'b0, ch0_pos_src}, pin_cfg_q);
         ch0_neg_sel <= (use_alt_q ? input_sel_q[12] : input_sel_q[4]) ? route_pin(5'h01, pin_cfg_q)
                                                                        : adcis_pkg::NEG_VREF_MINUS;
         // Upper channels follow the same set
         ch1_pos_sel <= route_pin(upper_pos_base, pin_cfg_q);
         ch2_pos_sel <= route_pin(upper_pos_base + 5'h01, pin_cfg_q);
         ch3_pos_sel <= route_pin(upper_pos_base + 5'h02, pin_cfg_q);
         unique case (use_alt_q ? input_sel_q[15:14] : input_sel_q[7:6])
            2'h2: chx_neg_sel <= route_pin(5'h06, pin_cfg_q);
            2'h3: chx_neg_sel <= route_pin(5'h09, pin_cfg_q);
            default: chx_neg_sel <= adcis_pkg::NEG_VREF_MINUS;
         endcase
      end
   end

   // Power, reference, pin buffers and sequence shape
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         module_powered <= 1'b0;
         reference_select <= 3'h0;
         digital_buffer_en <= 16'h0000;
         channel_count_select <= 2'h0;
         simultaneous_sample <= 1'b0;
      end
      else if (clk_en)
      begin
         module_powered <= on;
         reference_select <= ctrl_two_q[15:13];
         digital_buffer_en <= pin_cfg_q;
         // Code 3 behaves as 2: four channels
         channel_count_select <= ctrl_two_q[9] ? 2'h2 : {1'b0, ctrl_two_q[8]};
         simultaneous_sample <= ctrl_one_q[adcis_pkg::SIM_SAMPLE_BIT] && (ctrl_two_q[9:8] != 2'h0);
      end
   end

   logic [5:0] tick_gap_q;
   logic gap_ok_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_gap_q <= 6'h00;
         gap_ok_q <= 1'b0;
      end
      else if (clk_en)
      begin
         tick_gap_q <= tad_tick ? 6'h00 : (tick_gap_q == 6'h3F ? 6'h3F : tick_gap_q + 6'h01);
         gap_ok_q <= on && (gap_ok_q || tad_tick);
      end
   end

   AST_PORT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && clk_en && paddr == adcis_pkg::ADDR_PORT_READ)
      |=> ((prdata[15:0] & ~$past(pin_cfg_q)) == 16'h0000)) else $error("analog pin read nonzero");
   AST_DIGITAL_GROUND: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && pin_cfg_q[ch0_pos_src]) |=> (ch0_pos_sel == adcis_pkg::SEL_GROUND))
      else $error("digital pin not grounded");
   AST_OFF_POWER: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !on) |=> (!module_powered && !conv_clock_tick)) else $error("module powered while off");
   AST_CONV_TWELVE: assert property (@(posedge pclk) disable iff (!presetn)
      (conversion_done && $past(clk_en)) |-> tad_cnt_q == 4'h0 && $past(tad_cnt_q) == 4'hB)
      else $error("conversion not twelve clocks");
   AST_NO_ALT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !alt_en) |=> !use_alt_q) else $error("alternate set used while disabled");
   AST_SCAN_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && conv_irq_event) |=> scan_ptr_q == next_low($past(scan_sel_q)))
      else $error("scan did not restart");
   AST_DIV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !on) |=> (div_cnt_q == 7'h00 && !half_tick_q)) else $error("divider running while off");
   AST_RC_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_three_q[adcis_pkg::RC_SEL_BIT] && !(rc_meta_q[1] && !rc_prev_q)) |=> !conv_clock_tick)
      else $error("divider used under RC select");
   AST_TAD_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && on && gap_ok_q && tad_tick && !ctrl_three_q[adcis_pkg::RC_SEL_BIT])
      |-> ({1'b0, tick_gap_q} + 7'h01) == (({1'b0, ctrl_three_q[5:0]} + 7'h02) >> 1))
      else $error("conversion clock period wrong");
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] pin_level;
   logic [15:0] level_set = 16'h0000;
   logic rc_run = 1'b0;
   logic rc_clock_tick;
   logic sample_event = 1'b0;
   logic [1:0] sample_channel = 2'h0;
   logic conv_irq_event = 1'b0;
   logic module_powered;
   logic [2:0] reference_select;
   logic [15:0] digital_buffer_en;
   logic conv_clock_tick;
   logic conversion_done;
   logic [4:0] ch0_pos_sel, ch0_neg_sel, ch1_pos_sel, ch2_pos_sel, ch3_pos_sel, chx_neg_sel;
   logic [1:0] channel_count_select;
   logic simultaneous_sample;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic er;
   logic [15:0] m_sel = 16'h0000;
   logic [15:0] m_cfg = 16'h0000;
   logic [15:0] m_scan, m_two, m_one;
   int m_ptr = 0;
   bit m_alt = 1'b0;
   int divs[4] = '{6, 7, 20, 63};

   adcis_top #(.N_INPUTS(16)) u_adcis_top (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pin_level, .rc_clock_tick, .sample_event, .sample_channel,
      .conv_irq_event, .module_powered, .reference_select, .digital_buffer_en, .conv_clock_tick,
      .conversion_done, .ch0_pos_sel, .ch0_neg_sel, .ch1_pos_sel, .ch2_pos_sel, .ch3_pos_sel,
      .chx_neg_sel, .channel_count_select, .simultaneous_sample);
   adcis_analog_side u_adcis_analog_side (.rc_run, .level_set, .pin_level, .rc_clock_tick);

   always #12.5 pclk = ~pclk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard, far above the expected run length
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         bad_count++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp, input string what);
      num_checks++;
      if (got != exp)
      begin
         bad_count++;
         $display("mismatch at %0t: %s count %0d expected %0d", $time, what, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Fields that must not move while on are written with the module off
   task automatic cfg(input logic [15:0] one, input logic [15:0] two, input logic [15:0] three,
      input logic [15:0] scan);
      m_one = one;
      m_two = two;
      m_scan = scan;
      m_alt = 1'b0;
      apb(1'b1, adcis_pkg::ADDR_CTRL_ONE, {16'h0000, one});
      apb(1'b1, adcis_pkg::ADDR_CTRL_TWO, {16'h0000, two});
      apb(1'b1, adcis_pkg::ADDR_CTRL_THREE, {16'h0000, three});
      apb(1'b1, adcis_pkg::ADDR_SCAN_SEL, {16'h0000, scan});
      apb(1'b1, adcis_pkg::ADDR_CTRL_ONE, {16'h0000, one | 16'h8000});
   endtask

   function automatic int nxt(input int p);
      for (int i = p + 1; i <= p + 16; i++)
         if (m_scan[i % 16])
            return i % 16;
      return 0;
   endfunction

   function automatic int g(input int i);
      return (i < 16 && m_cfg[i]) ? 31 : i;
   endfunction

   task automatic pulse(input bit irq_sel, input int ch);
      int lastch;
      lastch = (m_two[9:8] == 2'h0) ? 0 : ((m_two[9:8] == 2'h1) ? 1 : 3);
      @(posedge pclk);
      conv_irq_event <= irq_sel;
      sample_event <= !irq_sel;
      sample_channel <= 2'(ch);
      @(posedge pclk);
      conv_irq_event <= 1'b0;
      sample_event <= 1'b0;
      if (irq_sel)
         m_ptr = nxt(15);
      else
      begin
         if (ch == 0 && !m_alt && m_two[10])
            m_ptr = nxt(m_ptr);
         if (m_two[0] && (m_one[3] || ch == lastch))
            m_alt = !m_alt;
      end
   endtask

   task automatic chk_mux();
      logic [7:0] b;
      int up;
      int un;
      b = m_alt ? m_sel[15:8] : m_sel[7:0];
      up = b[5] ? 3 : 0;
      un = !b[7] ? 16 : (b[6] ? 9 : 6);
      wt(3);
      chk(ch0_pos_sel, g((m_two[10] && !m_alt) ? m_ptr : b[3:0]), "ch0 pos");
      chk(ch0_neg_sel, g(b[4] ? 1 : 16), "ch0 neg");
      chk(ch1_pos_sel, g(up), "ch1 pos");
      chk(ch2_pos_sel, g(up + 1), "ch2 pos");
      chk(ch3_pos_sel, g(up + 2), "ch3 pos");
      chk(chx_neg_sel, g(un), "upper neg");
   endtask

   task automatic tick_gap(output int t);
      t = 0;
      while (conv_clock_tick !== 1'b1 && t < 200)
      begin
         @(posedge pclk);
         t++;
      end
      t = 0;
      do
      begin
         @(posedge pclk);
         t++;
      end
      while (conv_clock_tick !== 1'b1 && t < 200);
   endtask

   task automatic count(input int cyc, output int n, output int r);
      logic p;
      n = 0;
      r = 0;
      p = rc_clock_tick;
      repeat (cyc)
      begin
         @(posedge pclk);
         n += (conv_clock_tick === 1'b1);
         r += (rc_clock_tick === 1'b1 && p === 1'b0);
         p = rc_clock_tick;
      end
   endtask

   initial
   begin
      int n;
      int r;
      int t;
      void'($urandom(91105));
      level_set <= 16'($urandom);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      wt(2);
      chk({module_powered, reference_select, digital_buffer_en, simultaneous_sample, channel_count_select}, 0,
         "reset outputs");
      chk({ch0_pos_sel, ch0_neg_sel, chx_neg_sel}, {5'h00, 5'h10, 5'h10}, "reset mux");
      // Port read included: all pins analog so it reads zero
      for (int a = 0; a < 7; a++)
      begin
         apb(1'b0, 8'(a * 4), 32'h00000000);
         chk(rd, 32'h00000000, "reset register");
      end
      apb(1'b0, adcis_pkg::ADDR_EVENT, 32'h00000000);
      chk(er, 1'b1, "unmapped error");
      chk(rd, 32'h00000000, "unmapped data");
      for (int v = 0; v < 8; v++)
      begin
         cfg(16'((v % 2) << 3), 16'((v << 13) | ((v / 2) << 8)), 16'h0006, 16'h0001);
         wt(3);
         chk(reference_select, v, "reference");
         chk(channel_count_select, (v / 2 == 3) ? 2 : v / 2, "channel count");
         chk(simultaneous_sample, (v % 2) && (v / 2 != 0), "simultaneous");
         chk(module_powered, 1'b1, "powered");
      end
      apb(1'b1, adcis_pkg::ADDR_CTRL_ONE, 32'h00000000);
      wt(2);
      count(100, n, r);
      chk(module_powered, 1'b0, "powered off");
      chk_cnt(n, 0, "ticks while off");
      // Divider values at or above the minimum period only
      foreach (divs[i])
      begin
         cfg(16'h0000, 16'h0000, 16'(divs[i]), 16'h0000);
         tick_gap(t);
         chk_cnt(t, (divs[i] + 2) / 2, "tad period");
         pulse(1'b0, 0);
         t = 0;
         while (conversion_done !== 1'b1 && t < 2000)
         begin
            @(posedge pclk);
            t++;
         end
         // Count from one conversion end to the next
         n = 0;
         t = 0;
         do
         begin
            @(posedge pclk);
            t++;
            n += (conv_clock_tick === 1'b1);
         end
         while (conversion_done !== 1'b1 && t < 2000);
         chk_cnt(n, 12, "tad per conversion");
      end
      wt(1);
      clk_en <= 1'b0;
      count(100, n, r);
      chk_cnt(n, 0, "ticks while frozen");
      clk_en <= 1'b1;
      rc_run <= 1'b1;
      cfg(16'h0000, 16'h0000, 16'h0080, 16'h0000);
      wt(10);
      count(400, n, r);
      chk_cnt((n - r) inside {[-2:2]}, 1, "rc ticks");
      rc_run <= 1'b0;
      m_sel = 16'($urandom);
      apb(1'b1, adcis_pkg::ADDR_INPUT_SEL, {16'h0000, m_sel});
      cfg(16'h0000, 16'h0001, 16'h0006, 16'h0000);
      chk_mux();
      repeat (2)
      begin
         pulse(1'b0, 0);
         chk_mux();
      end
      cfg(16'h0008, 16'h0201, 16'h0006, 16'h0000);
      repeat (2)
      begin
         pulse(1'b0, 0);
         chk_mux();
      end
      cfg(16'h0000, 16'h0101, 16'h0006, 16'h0000);
      repeat (2)
      begin
         pulse(1'b0, 0);
         chk_mux();
         pulse(1'b0, 1);
         chk_mux();
      end
      cfg(16'h0000, 16'h0401, 16'h0006, 16'($urandom) | 16'h0101);
      pulse(1'b1, 0);
      chk_mux();
      repeat (6)
      begin
         pulse(1'b0, 0);
         chk_mux();
      end
      pulse(1'b1, 0);
      chk_mux();
      cfg(16'h0000, 16'h0000, 16'h0006, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         m_sel = (16'($urandom) & 16'hFF3F) | 16'((i % 4) << 6);
         m_cfg = 16'($urandom);
         level_set <= 16'($urandom);
         apb(1'b1, adcis_pkg::ADDR_INPUT_SEL, {16'h0000, m_sel});
         apb(1'b1, adcis_pkg::ADDR_PIN_CFG, {16'h0000, m_cfg});
         chk_mux();
         chk(digital_buffer_en, m_cfg, "buffer enables");
         apb(1'b0, adcis_pkg::ADDR_PORT_READ, 32'h00000000);
         chk(rd, {16'h0000, level_set & m_cfg}, "port read");
         apb(1'b0, adcis_pkg::ADDR_INPUT_SEL, 32'h00000000);
         chk(rd, {16'h0000, m_sel}, "select readback");
      end
      end_sim();
   end
endmodule
`default_nettype wire
